// File: hdl/dma_status_pkg.sv
// Register map and constants of the DMA controller status monitor
package dma_status_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_COLLISION = 8'h00;
    localparam logic [7:0] OFF_ACTIVITY  = 8'h04;
    localparam logic [7:0] OFF_LAST_ADDR = 8'h08;
    localparam logic [7:0] OFF_IRQ_STAT  = 8'h0C;
    localparam logic [7:0] OFF_IRQ_EN    = 8'h10;
    localparam logic [7:0] OFF_IRQ_CLR   = 8'h14;
    localparam logic [7:0] OFF_PP_MODE   = 8'h18;

    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam int         NUM_CH          = 8;
    localparam int         PWCOL_LSB       = 8;
    localparam int         XWCOL_LSB       = 0;
    localparam int         LAST_CH_LSB     = 8;
    localparam int         PPSEL_LSB       = 0;
    localparam logic [3:0] LAST_CH_NONE    = 4'hF;
    localparam logic [15:0] COLL_RESET     = 16'h0000;
    localparam logic [7:0] PPSEL_RESET     = 8'h00;
    localparam logic [15:0] ADDR_RESET     = 16'h0000;
    localparam logic [2:0] IRQ_RESET       = 3'h0;
    // Interrupt status bits
    localparam int         IRQ_PWCOL       = 0;
    localparam int         IRQ_XWCOL       = 1;
    localparam int         IRQ_XFER        = 2;
    // Ping-pong mode per channel: 2 bits, bit1 ping-pong on, bit0 one-shot
    localparam logic [1:0] PP_OFF_CONT     = 2'h0;
    localparam logic [1:0] PP_OFF_ONESHOT  = 2'h1;
    localparam logic [1:0] PP_ON_CONT      = 2'h2;
    localparam logic [1:0] PP_ON_ONESHOT   = 2'h3;
    localparam logic [15:0] PP_MODE_RESET  = 16'h0000;

    // ------------------------------------------------------------------
    // AHB-Lite encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ   = 2'h2;
    localparam logic [1:0] HTRANS_SEQ      = 2'h3;
    localparam logic [2:0] HSIZE_WORD      = 3'h2;

endpackage

// File: hdl/dma_status_monitor.sv
// Shared status registers of an eight-channel DMA controller
`timescale 1ns/1ps
`default_nettype none

module dma_status_monitor
    import dma_status_pkg::*;
(
    // Clock and reset
    input  wire logic        SYS_CLK_I,
    input  wire logic        RSTN_I,
    // AHB-Lite slave
    input  wire logic        HSEL_I,
    input  wire logic [7:0]  HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic        HREADY_I,
    input  wire logic [31:0] HWDATA_I,
    output logic      [31:0] HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    // Channel events from the transfer engines
    input  wire logic [7:0]  PERIPH_COLLIDE_I,
    input  wire logic [7:0]  RAM_COLLIDE_I,
    input  wire logic [7:0]  XFER_DONE_I,
    input  wire logic [7:0]  BLOCK_DONE_I,
    input  wire logic [7:0]  CH_ENABLE_I,
    input  wire logic        RAM_ACCESS_I,
    input  wire logic [15:0] RAM_ADDR_I,
    // Status toward the engines and the CPU
    output logic      [7:0]  BUF_SELECT_O,
    output logic      [7:0]  PP_HALT_O,
    output logic             IRQ_O
);

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic        wr_pend_r;
    logic        rd_pend_r;
    logic [7:0]  addr_r;
    logic [15:0] coll_r;
    logic [3:0]  last_ch_r;
    logic [7:0]  ppsel_r;
    logic [15:0] ram_addr_r;
    logic [2:0]  irq_stat_r;
    logic [2:0]  irq_en_r;
    logic [15:0] pp_mode_r;
    logic [7:0]  pp_done_r;
    logic        irq_r;

    wire addr_ph = HSEL_I && HREADY_I && HTRANS_I[1];
    wire wr_coll = wr_pend_r && addr_r == OFF_COLLISION;
    wire wr_en   = wr_pend_r && addr_r == OFF_IRQ_EN;
    wire wr_clr  = wr_pend_r && addr_r == OFF_IRQ_CLR;
    wire wr_mode = wr_pend_r && addr_r == OFF_PP_MODE;

    // ------------------------------------------------------------------
    // Collision flags
    // ------------------------------------------------------------------
    // write zero clears
    wire [15:0] coll_keep = wr_coll ? HWDATA_I[15:0] : 16'hFFFF;
    wire [15:0] coll_set  = {PERIPH_COLLIDE_I, RAM_COLLIDE_I};
    wire [15:0] coll_nxt  = (coll_r & coll_keep) | coll_set;

    // ------------------------------------------------------------------
    // Last channel: lowest completing channel is reported
    // ------------------------------------------------------------------
    logic [3:0] done_ch;
    always_comb begin
        done_ch = last_ch_r;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (XFER_DONE_I[i]) begin
                done_ch = 4'(i);
            end
        end
    end

    // ------------------------------------------------------------------
    // Ping-pong buffer selection
    // ------------------------------------------------------------------
    logic [7:0] ppsel_nxt;
    logic [7:0] pp_done_nxt;
    always_comb begin
        ppsel_nxt   = ppsel_r;
        pp_done_nxt = pp_done_r;
        for (int i = 0; i < NUM_CH; i++) begin
            // Disabling a channel clears the halt of its one-shot pair
            if (!CH_ENABLE_I[i]) begin
                pp_done_nxt[i] = 1'b0;
            end
            if (BLOCK_DONE_I[i] && pp_mode_r[2*i+1] && !pp_done_r[i]) begin
                ppsel_nxt[i] = ~ppsel_r[i];
                if (pp_mode_r[2*i] && ppsel_r[i]) begin
                    pp_done_nxt[i] = 1'b1;
                end
            end
            if (!pp_mode_r[2*i+1]) begin
                ppsel_nxt[i] = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------------
    wire [2:0] irq_ev  = {|XFER_DONE_I, |RAM_COLLIDE_I, |PERIPH_COLLIDE_I};
    wire [2:0] irq_clr = wr_clr ? HWDATA_I[2:0] : 3'h0;
    wire [2:0] irq_nxt = (irq_stat_r & ~irq_clr) | irq_ev;

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    // Read data is registered at the address phase so it stands in the
    // data phase straight from a flip-flop.
    wire [7:0]   rd_addr = {HADDR_I[7:2], 2'b00};
    logic [31:0] rdata_ahead;
    always_comb begin
        unique case (rd_addr)
            OFF_COLLISION: rdata_ahead = {16'h0000, coll_r};
            OFF_ACTIVITY:  rdata_ahead = {20'h00000, last_ch_r, ppsel_r};
            OFF_LAST_ADDR: rdata_ahead = {16'h0000, ram_addr_r};
            OFF_IRQ_STAT:  rdata_ahead = {29'h00000000, irq_stat_r};
            OFF_IRQ_EN:    rdata_ahead = {29'h00000000, irq_en_r};
            OFF_PP_MODE:   rdata_ahead = {16'h0000, pp_mode_r};
            default:       rdata_ahead = 32'h00000000;
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r    <= 8'h00;
            HRDATA_O  <= 32'h00000000;
        end else begin
            wr_pend_r <= addr_ph && HWRITE_I;
            rd_pend_r <= addr_ph && !HWRITE_I;
            if (addr_ph) begin
                addr_r <= {HADDR_I[7:2], 2'b00};
            end
            HRDATA_O  <= rd_pend_r ? 32'h00000000 : HRDATA_O;
            if (addr_ph && !HWRITE_I) begin
                HRDATA_O <= rdata_ahead;
            end
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            coll_r     <= COLL_RESET;
            last_ch_r  <= LAST_CH_NONE;
            ppsel_r    <= PPSEL_RESET;
            pp_done_r  <= PPSEL_RESET;
            ram_addr_r <= ADDR_RESET;
            irq_stat_r <= IRQ_RESET;
            irq_en_r   <= IRQ_RESET;
            pp_mode_r  <= PP_MODE_RESET;
            irq_r      <= 1'b0;
        end else begin
            coll_r     <= coll_nxt;
            last_ch_r  <= done_ch;
            ppsel_r    <= ppsel_nxt;
            pp_done_r  <= pp_done_nxt;
            if (RAM_ACCESS_I) begin
                ram_addr_r <= RAM_ADDR_I;
            end
            irq_stat_r <= irq_nxt;
            if (wr_en) begin
                irq_en_r <= HWDATA_I[2:0];
            end
            if (wr_mode) begin
                pp_mode_r <= HWDATA_I[15:0];
            end
            irq_r      <= |(irq_nxt & (wr_en ? HWDATA_I[2:0] : irq_en_r));
        end
    end

    assign HREADYOUT_O  = 1'b1;
    assign HRESP_O      = 1'b0;
    assign BUF_SELECT_O = ppsel_r;
    assign PP_HALT_O    = pp_done_r;
    assign IRQ_O        = irq_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_pwcol_set;
        @(posedge SYS_CLK_I) disable iff (!RSTN_I)
        PERIPH_COLLIDE_I[0] |=> coll_r[PWCOL_LSB];
    endproperty
    a_pwcol_set: assert property (p_pwcol_set)
        else $error("peripheral collision flag not set");

    property p_xwcol_set;
        @(posedge SYS_CLK_I) disable iff (!RSTN_I)
        RAM_COLLIDE_I[7] |=> coll_r[XWCOL_LSB + 7];
    endproperty
    a_xwcol_set: assert property (p_xwcol_set)
        else $error("RAM collision flag not set");

    property p_coll_sticky;
        @(posedge SYS_CLK_I) disable iff (!RSTN_I)
        (coll_r[3] && !wr_coll) |=> coll_r[3];
    endproperty
    a_coll_sticky: assert property (p_coll_sticky)
        else $error("collision flag lost without a clear");

    property p_last_range;
        @(posedge SYS_CLK_I) disable iff (!RSTN_I)
        last_ch_r[3] |-> last_ch_r == LAST_CH_NONE;
    endproperty
    a_last_range: assert property (p_last_range)
        else $error("reserved last-channel code");

    property p_last_load;
        @(posedge SYS_CLK_I) disable iff (!RSTN_I)
        (XFER_DONE_I == 8'h20) |=> last_ch_r == 4'h5;
    endproperty
    a_last_load: assert property (p_last_load)
        else $error("last channel not loaded");

    property p_pp_toggle;
        @(posedge SYS_CLK_I) disable iff (!RSTN_I)
        (BLOCK_DONE_I[2] && pp_mode_r[5] && !pp_done_r[2] && !wr_mode)
            |=> ppsel_r[2] != $past(ppsel_r[2]);
    endproperty
    a_pp_toggle: assert property (p_pp_toggle)
        else $error("buffer select did not alternate");

    property p_pp_primary;
        @(posedge SYS_CLK_I) disable iff (!RSTN_I)
        !pp_mode_r[1] |=> !ppsel_r[0] || pp_mode_r[1];
    endproperty
    a_pp_primary: assert property (p_pp_primary)
        else $error("buffer select set without ping-pong");

    property p_addr_cap;
        @(posedge SYS_CLK_I) disable iff (!RSTN_I)
        RAM_ACCESS_I |=> ram_addr_r == $past(RAM_ADDR_I);
    endproperty
    a_addr_cap: assert property (p_addr_cap)
        else $error("RAM address not captured");

    property p_act_upper;
        @(posedge SYS_CLK_I) disable iff (!RSTN_I)
        (addr_ph && !HWRITE_I && HADDR_I == OFF_ACTIVITY)
            |=> HRDATA_O[31:12] == 20'h00000;
    endproperty
    a_act_upper: assert property (p_act_upper)
        else $error("unimplemented bits read nonzero");

    property p_last_none_hold;
        @(posedge SYS_CLK_I) disable iff (!RSTN_I)
        (last_ch_r == LAST_CH_NONE && XFER_DONE_I == 8'h00)
            |=> last_ch_r == LAST_CH_NONE;
    endproperty
    a_last_none_hold: assert property (p_last_none_hold)
        else $error("idle last-channel code lost without a transfer");

    property p_set_wins;
        @(posedge SYS_CLK_I) disable iff (!RSTN_I)
        (wr_coll && RAM_COLLIDE_I[0]) |=> coll_r[XWCOL_LSB];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("clear beat a simultaneous collision");

    property p_wr_clear;
        @(posedge SYS_CLK_I) disable iff (!RSTN_I)
        (wr_coll && !HWDATA_I[XWCOL_LSB] && !RAM_COLLIDE_I[0])
            |=> !coll_r[XWCOL_LSB];
    endproperty
    a_wr_clear: assert property (p_wr_clear)
        else $error("writing zero did not clear the flag");

    property p_pp_halt_hold;
        @(posedge SYS_CLK_I) disable iff (!RSTN_I)
        (pp_done_r[1] && pp_mode_r[3]) |=> ppsel_r[1] == $past(ppsel_r[1]);
    endproperty
    a_pp_halt_hold: assert property (p_pp_halt_hold)
        else $error("halted one-shot channel changed buffer");

endmodule

`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the DMA controller status monitor
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
    err_count++; $display("CHECK FAILED t=%0t got %h exp %h", \
    $time, got, exp); end end

module tb;
    import dma_status_pkg::*;

    // --------------------------------------------------------------
    // Signals
    // --------------------------------------------------------------
    logic        sys_clk;
    logic        rstn;
    logic        hsel;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [7:0]  pcol;
    logic [7:0]  rcol;
    logic [7:0]  xdone;
    logic [7:0]  bdone;
    logic [7:0]  chen;
    logic        ram_acc;
    logic [15:0] ram_addr;
    logic [7:0]  buf_sel;
    logic [7:0]  pp_halt;
    logic        irq;
    int          err_count;
    int          checks_done;

    dma_status_monitor DUT (
        .SYS_CLK_I(sys_clk), .RSTN_I(rstn), .HSEL_I(hsel),
        .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
        .HSIZE_I(hsize), .HREADY_I(hreadyout), .HWDATA_I(hwdata),
        .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout), .HRESP_O(hresp),
        .PERIPH_COLLIDE_I(pcol), .RAM_COLLIDE_I(rcol),
        .XFER_DONE_I(xdone), .BLOCK_DONE_I(bdone), .CH_ENABLE_I(chen),
        .RAM_ACCESS_I(ram_acc), .RAM_ADDR_I(ram_addr),
        .BUF_SELECT_O(buf_sel), .PP_HALT_O(pp_halt), .IRQ_O(irq));

    always #5 sys_clk = ~sys_clk;

    // --------------------------------------------------------------
    // Bus and event tasks
    // --------------------------------------------------------------
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Wait for hready under a bound; a hang ends the run
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            err_count++;
            report_and_stop();
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rdat);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize  <= HSIZE_WORD;
        wait_ready();
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        wait_ready();
        rdat = hrdata;
        `CHK(hresp, 1'b0)
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] dummy;
        bus(1'b1, a, wd, dummy);
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] got;
        bus(1'b0, a, 32'h0, got);
        `CHK(got, exp)
    endtask

    // One-cycle event pulse, then let the status settle
    task automatic ev(input logic [7:0] p, input logic [7:0] r,
                      input logic [7:0] x, input logic [7:0] b);
        pcol  <= p;
        rcol  <= r;
        xdone <= x;
        bdone <= b;
        @(posedge sys_clk);
        {pcol, rcol, xdone, bdone} <= 32'h0;
        repeat (2) @(posedge sys_clk);
    endtask

    initial begin
        #200us;
        err_count++;
        report_and_stop();
    end

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        sys_clk = 1'b0; rstn = 1'b0; hsel = 1'b0; haddr = 8'h00;
        htrans = 2'h0; hwrite = 1'b0; hsize = HSIZE_WORD; hwdata = 32'h0;
        pcol = 8'h00; rcol = 8'h00; xdone = 8'h00; bdone = 8'h00;
        chen = 8'hFF; ram_acc = 1'b0; ram_addr = 16'h0000;
        err_count = 0; checks_done = 0;
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        chk_rd(OFF_COLLISION, 32'h0000_0000);
        chk_rd(OFF_ACTIVITY, 32'h0000_0F00);
        chk_rd(OFF_LAST_ADDR, 32'h0000_0000);
        `CHK(buf_sel, 8'h00)
        chk_rd(8'h1C, 32'h0000_0000);
        $display("test reset values done");

        ev(8'hA5, 8'hBC, 8'h00, 8'h00);
        chk_rd(OFF_COLLISION, 32'h0000_A5BC);
        wr(OFF_COLLISION, 32'h0000_FF00);
        chk_rd(OFF_COLLISION, 32'h0000_A500);
        fork
            wr(OFF_COLLISION, 32'h0000_0000);
            begin
                @(posedge sys_clk);
                rcol <= 8'h01;
                @(posedge sys_clk);
                rcol <= 8'h00;
            end
        join
        chk_rd(OFF_COLLISION, 32'h0000_0001);
        $display("test collision flags done");

        for (int ch = 0; ch < NUM_CH; ch++) begin
            ev(8'h00, 8'h00, 8'h01 << ch, 8'h00);
            chk_rd(OFF_ACTIVITY, {20'h0, ch[3:0], 8'h00});
        end
        ev(8'h00, 8'h00, 8'h0C, 8'h00);
        chk_rd(OFF_ACTIVITY, 32'h0000_0200);
        wr(OFF_ACTIVITY, 32'hFFFF_FFFF);
        chk_rd(OFF_ACTIVITY, 32'h0000_0200);
        $display("test last channel done");

        wr(OFF_PP_MODE, {26'h0, PP_ON_CONT, PP_ON_ONESHOT, PP_ON_CONT});
        ev(8'h00, 8'h00, 8'h00, 8'h0F);
        `CHK(buf_sel, 8'h07)
        chk_rd(OFF_ACTIVITY, 32'h0000_0207);
        ev(8'h00, 8'h00, 8'h00, 8'h03);
        `CHK(buf_sel[0], 1'b0)
        `CHK(pp_halt, 8'h02)
        chen <= 8'hFD;
        repeat (2) @(posedge sys_clk);
        `CHK(pp_halt, 8'h00)
        chen <= 8'hFF;
        $display("test ping-pong done");

        ram_addr <= 16'hBEEF;
        ram_acc  <= 1'b1;
        @(posedge sys_clk);
        ram_acc  <= 1'b0;
        ram_addr <= 16'h0000;
        chk_rd(OFF_LAST_ADDR, 32'h0000_BEEF);
        wr(OFF_LAST_ADDR, 32'h0000_1234);
        chk_rd(OFF_LAST_ADDR, 32'h0000_BEEF);
        $display("test ram address done");

        wr(OFF_IRQ_CLR, 32'h0000_0007);
        wr(OFF_IRQ_EN, 32'h0000_0000);
        ev(8'h10, 8'h00, 8'h00, 8'h00);
        chk_rd(OFF_IRQ_STAT, 32'h0000_0001);
        `CHK(irq, 1'b0)
        wr(OFF_IRQ_EN, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        `CHK(irq, 1'b1)
        wr(OFF_IRQ_CLR, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        `CHK(irq, 1'b0)
        chk_rd(OFF_IRQ_STAT, 32'h0000_0000);
        wr(8'h1C, 32'hFFFF_FFFF);
        chk_rd(8'h1C, 32'h0000_0000);
        $display("test interrupts done");
        report_and_stop();
    end
endmodule

`default_nettype wire
